// file: attc_top.sv
// acquisition sequencer: triggers, scan timing, data fifo and transfer events
module attc_top (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // configuration and command
   input wire attc_pkg::attc_cfg_t i_cfg,
   input wire logic i_start,
   // external pins
   input wire logic i_ext_trig,
   input wire logic i_ext_tb,
   // converter
   output logic o_conv_start,
   output logic [8:0] o_conv_entry,
   input wire logic i_conv_done,
   input wire logic [15:0] i_conv_data,
   // data stream to the host or dma master
   output logic o_dat_valid,
   output logic [15:0] o_dat_word,
   input wire logic i_dat_ready,
   // events and status
   output logic o_eoc_irq,
   output logic o_half_irq,
   output logic o_busy,
   output logic o_overflow,
   output logic [10:0] o_fifo_level
);
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_RUN} attc_state_t;

   // ****************************************
   // registers
   // ****************************************
   attc_state_t st_q, st_d;
   logic [6:0] acc_q;
   logic tb_prev_q;
   logic trg_s1_q, trg_s2_q, trg_s3_q;
   logic [23:0] si_q, si_d;
   logic [15:0] sp_q, sp_d;
   logic [8:0] idx_q, idx_d;
   logic [8:0] ent_q, ent_d;
   logic in_scan_q, in_scan_d;
   logic [31:0] iss_q, iss_d;
   logic [31:0] pre_end_q, pre_end_d;
   logic post_q, post_d;
   logic trig_q, trig_d;
   logic [23:0] left_q, left_d;
   logic [15:0] dly_q, dly_d;
   logic [15:0] ddiv_q, ddiv_d;
   logic [15:0] rtg_q, rtg_d;
   logic start_d;
   logic [8:0] wdx_q;
   logic [31:0] wscan_q;
   logic [15:0] held_q;
   logic [25:0] cnt_q;
   logic rel_q;
   logic hi_q;
   logic drop;
   logic fifo_full, fifo_valid, skid_ready;
   logic [15:0] fifo_data;
   logic [10:0] fifo_level;

   // ****************************************
   // decode
   // ****************************************
   wire logic pre_mode = (i_cfg.mode == attc_pkg::ATTC_PRE) || (i_cfg.mode == attc_pkg::ATTC_MID);
   wire logic is_mid = (i_cfg.mode == attc_pkg::ATTC_MID);
   wire logic is_dma = (i_cfg.xfer == attc_pkg::ATTC_X_DMA);
   wire logic go = (st_q == ST_IDLE) && i_start;
   // internal timebase: 24 ticks per 100 clocks via a fractional accumulator
   wire logic [6:0] acc_sum = acc_q + attc_pkg::TB_ACC_STEP;
   wire logic tick_int = (acc_sum >= attc_pkg::TB_ACC_WRAP);
   wire logic tb_tick = i_cfg.tb_ext ? (i_ext_tb && !tb_prev_q) : tick_int;
   // edge taken between second and third flop only
   wire logic trig_edge = i_cfg.trig_falling ? (trg_s3_q && !trg_s2_q)
                                             : (!trg_s3_q && trg_s2_q);
   wire logic [8:0] n_scan = (i_cfg.spscan == 9'h000) ? 9'h001 : i_cfg.spscan;
   wire logic cap_hit = is_dma && (cnt_q == attc_pkg::DMA_MAX_SAMPLES);
   wire logic guard_ok = !i_cfg.guard_en || (wscan_q >= {16'h0000, i_cfg.pre_count});
   wire logic accept = (st_q == ST_RUN) && pre_mode && !trig_q && trig_edge && guard_ok;
   wire logic dly_tick = i_cfg.dly_smp_clk ? (tb_tick && ddiv_q == 16'h0000) : tb_tick;
   wire logic [8:0] ent_nx = (ent_q + 9'h001 >= n_scan) ? 9'h000 : ent_q + 9'h001;
   wire logic run_end = !in_scan_q && ((post_q && left_q == 24'h00_0000)
                        || (i_cfg.mode == attc_pkg::ATTC_PRE && trig_q) || cap_hit);
   wire logic more_trig = i_cfg.retrig_en && rtg_q < i_cfg.retrig_total
                          && (i_cfg.mode == attc_pkg::ATTC_POST
                              || i_cfg.mode == attc_pkg::ATTC_DELAY);
   wire logic may_start = !in_scan_q && !accept && !run_end;
   // write side
   wire logic wr_ok = i_conv_done && !cap_hit;
   wire logic scan_fin = i_conv_done && (wdx_q + 9'h001 >= n_scan);
   wire logic pre_scan = pre_mode && (!trig_q || wscan_q < pre_end_q);
   wire logic fifo_pop = fifo_valid && skid_ready && rel_q;

   // oldest finished scan is thrown away once the pre count is held
   assign drop = scan_fin && pre_scan && (held_q >= i_cfg.pre_count);

   // ****************************************
   // sequencer next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      si_d = si_q;
      sp_d = sp_q;
      idx_d = idx_q;
      ent_d = ent_q;
      in_scan_d = in_scan_q;
      iss_d = iss_q;
      pre_end_d = pre_end_q;
      post_d = post_q;
      trig_d = trig_q;
      left_d = left_q;
      dly_d = dly_q;
      ddiv_d = ddiv_q;
      rtg_d = rtg_q;
      start_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (i_start) begin
               si_d = 24'h00_0000;
               ent_d = 9'h000;
               in_scan_d = 1'b0;
               iss_d = attc_pkg::CNT_RST;
               pre_end_d = attc_pkg::CNT_RST;
               trig_d = 1'b0;
               rtg_d = 16'h0000;
               left_d = i_cfg.scan_count;
               post_d = (i_cfg.mode == attc_pkg::ATTC_SOFT);
               if (i_cfg.mode == attc_pkg::ATTC_POST || i_cfg.mode == attc_pkg::ATTC_DELAY) begin
                  st_d = ST_WAIT;
               end else begin
                  st_d = ST_RUN;
               end
            end
         end
         ST_WAIT: begin
            // post and delay triggers are only heard here, so early retriggers are lost
            if (trig_edge) begin
               rtg_d = rtg_q + 16'h0001;
               left_d = i_cfg.scan_count;
               post_d = 1'b1;
               si_d = 24'h00_0000;
               dly_d = i_cfg.dly_count;
               ddiv_d = 16'h0000;
               st_d = (i_cfg.mode == attc_pkg::ATTC_DELAY) ? ST_DELAY : ST_RUN;
            end
         end
         ST_DELAY: begin
            if (tb_tick) begin
               ddiv_d = (ddiv_q == 16'h0000) ? i_cfg.smp_int - 16'h0001 : ddiv_q - 16'h0001;
            end
            if (dly_q == 16'h0000) begin
               st_d = ST_RUN;
            end else if (dly_tick) begin
               dly_d = dly_q - 16'h0001;
            end
         end
         ST_RUN: begin
            if (accept) begin
               trig_d = 1'b1;
               // a scan under way stays pre in one mode and opens the post run in the other
               pre_end_d = (is_mid && in_scan_q) ? iss_q - 32'h0000_0001 : iss_q;
               if (is_mid) begin
                  post_d = 1'b1;
                  left_d = (in_scan_q && i_cfg.scan_count != 24'h00_0000)
                           ? i_cfg.scan_count - 24'h00_0001 : i_cfg.scan_count;
               end
            end
            if (run_end) begin
               st_d = more_trig ? ST_WAIT : ST_IDLE;
            end else if (tb_tick) begin
               si_d = (si_q == 24'h00_0000) ? i_cfg.scan_int - 24'h00_0001 : si_q - 24'h00_0001;
               if (si_q == 24'h00_0000 && may_start) begin
                  start_d = 1'b1;
                  idx_d = 9'h001;
                  in_scan_d = (n_scan != 9'h001);
                  sp_d = i_cfg.smp_int - 16'h0001;
                  iss_d = iss_q + 32'h0000_0001;
                  ent_d = ent_nx;
                  if (post_q) begin
                     left_d = left_q - 24'h00_0001;
                  end
               end else if (in_scan_q) begin
                  if (sp_q == 16'h0000) begin
                     start_d = 1'b1;
                     idx_d = idx_q + 9'h001;
                     in_scan_d = (idx_q + 9'h001 < n_scan);
                     sp_d = i_cfg.smp_int - 16'h0001;
                     ent_d = ent_nx;
                  end else begin
                     sp_d = sp_q - 16'h0001;
                  end
               end
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // sequencer registers
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         st_q <= ST_IDLE;
         si_q <= 24'h00_0000;
         sp_q <= 16'h0000;
         idx_q <= 9'h000;
         ent_q <= 9'h000;
         in_scan_q <= 1'b0;
         iss_q <= attc_pkg::CNT_RST;
         pre_end_q <= attc_pkg::CNT_RST;
         post_q <= 1'b0;
         trig_q <= 1'b0;
         left_q <= 24'h00_0000;
         dly_q <= 16'h0000;
         ddiv_q <= 16'h0000;
         rtg_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         si_q <= si_d;
         sp_q <= sp_d;
         idx_q <= idx_d;
         ent_q <= ent_d;
         in_scan_q <= in_scan_d;
         iss_q <= iss_d;
         pre_end_q <= pre_end_d;
         post_q <= post_d;
         trig_q <= trig_d;
         left_q <= left_d;
         dly_q <= dly_d;
         ddiv_q <= ddiv_d;
         rtg_q <= rtg_d;
      end
   end

   // ****************************************
   // timebase, trigger sync, converter strobe
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         acc_q <= attc_pkg::ACC_RST;
         tb_prev_q <= 1'b0;
         trg_s1_q <= 1'b0;
         trg_s2_q <= 1'b0;
         trg_s3_q <= 1'b0;
         o_conv_start <= 1'b0;
         o_conv_entry <= 9'h000;
         o_busy <= 1'b0;
      end else begin
         acc_q <= tick_int ? acc_sum - attc_pkg::TB_ACC_WRAP : acc_sum;
         tb_prev_q <= i_ext_tb;
         trg_s1_q <= i_ext_trig;
         trg_s2_q <= trg_s1_q;
         trg_s3_q <= trg_s2_q;
         o_conv_start <= start_d;
         if (start_d) begin
            o_conv_entry <= ent_q;
         end
         o_busy <= (st_d != ST_IDLE);
      end
   end

   // ****************************************
   // write side bookkeeping and events
   // ****************************************
   // release waits one clock after the last drop, so no doomed word leaks out
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || go) begin
         wdx_q <= 9'h000;
         wscan_q <= attc_pkg::CNT_RST;
         held_q <= 16'h0000;
         cnt_q <= 26'h000_0000;
         rel_q <= 1'b0;
         o_overflow <= 1'b0;
      end else begin
         if (i_conv_done) begin
            wdx_q <= scan_fin ? 9'h000 : wdx_q + 9'h001;
         end
         if (scan_fin) begin
            wscan_q <= wscan_q + 32'h0000_0001;
            if (pre_scan && !drop) begin
               held_q <= held_q + 16'h0001;
            end
         end
         if (wr_ok && is_dma) begin
            cnt_q <= cnt_q + 26'h000_0001;
         end
         rel_q <= !pre_mode || (trig_q && wscan_q >= pre_end_q);
         o_overflow <= o_overflow || (i_conv_done && fifo_full);
      end
   end

   // transfer events, one clock each
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_eoc_irq <= 1'b0;
         o_half_irq <= 1'b0;
         hi_q <= 1'b0;
         o_fifo_level <= 11'h000;
      end else begin
         o_eoc_irq <= (i_cfg.xfer == attc_pkg::ATTC_X_EOC) && wr_ok && !fifo_full;
         hi_q <= (fifo_level >= attc_pkg::HALF_LEVEL);
         o_half_irq <= (i_cfg.xfer == attc_pkg::ATTC_X_HALF)
                       && (fifo_level >= attc_pkg::HALF_LEVEL) && !hi_q;
         o_fifo_level <= fifo_level;
      end
   end

   // ****************************************
   // data path
   // ****************************************
   attc_fifo u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_flush(go),
      .i_drop(drop),
      .i_drop_n(n_scan),
      .i_wr(wr_ok),
      .i_wr_data(i_conv_data),
      .o_full(fifo_full),
      .i_pop(fifo_pop),
      .o_valid(fifo_valid),
      .o_rd_data(fifo_data),
      .o_level(fifo_level)
   );

   attc_skid u_skid (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_valid(fifo_valid && rel_q),
      .i_data(fifo_data),
      .o_ready(skid_ready),
      .o_valid(o_dat_valid),
      .o_data(o_dat_word),
      .i_ready(i_dat_ready)
   );
endmodule : attc_top

// file: attc_pkg.sv
// package: modes, config carrier and constants of the acquisition sequencer
package attc_pkg;

   // ****************************************
   // modes
   // ****************************************
   typedef enum logic [2:0] {ATTC_SOFT, ATTC_PRE, ATTC_MID, ATTC_POST, ATTC_DELAY} attc_mode_t;
   typedef enum logic [1:0] {ATTC_X_EOC, ATTC_X_HALF, ATTC_X_DMA} attc_xfer_t;

   // ****************************************
   // timebase and sizes
   // ****************************************
   localparam int SYS_CLK_MHZ = 100;
   localparam int TB_INT_MHZ = 24;
   localparam logic [6:0] TB_ACC_STEP = 7'(TB_INT_MHZ);
   localparam logic [6:0] TB_ACC_WRAP = 7'(SYS_CLK_MHZ);
   localparam int FIFO_AW = 10;
   localparam int FIFO_DEPTH = 1 << FIFO_AW;
   localparam logic [10:0] HALF_LEVEL = 11'h200;
   localparam int DMA_MAX_BYTES = 64 * 1024 * 1024;
   localparam int SAMPLE_BYTES = 2;
   localparam logic [25:0] DMA_MAX_SAMPLES = 26'(DMA_MAX_BYTES / SAMPLE_BYTES);

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [6:0] ACC_RST = 7'h00;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   // ****************************************
   // configuration carrier
   // ****************************************
   typedef struct packed {
      attc_mode_t mode;
      attc_xfer_t xfer;
      logic trig_falling;
      logic guard_en;
      logic retrig_en;
      logic tb_ext;
      logic dly_smp_clk;
      logic [8:0] spscan;
      logic [23:0] scan_count;
      logic [15:0] pre_count;
      logic [15:0] dly_count;
      logic [15:0] smp_int;
      logic [23:0] scan_int;
      logic [15:0] retrig_total;
   } attc_cfg_t;

endpackage : attc_pkg

// file: attc_fifo.sv
// data fifo: 1024 words, discard on full, drop of a whole scan, flush
module attc_fifo (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // control
   input wire logic i_flush,
   input wire logic i_drop,
   input wire logic [8:0] i_drop_n,
   // write side
   input wire logic i_wr,
   input wire logic [15:0] i_wr_data,
   output logic o_full,
   // read side
   input wire logic i_pop,
   output logic o_valid,
   output logic [15:0] o_rd_data,
   output logic [10:0] o_level
);
   logic [15:0] mem [attc_pkg::FIFO_DEPTH];
   logic [9:0] wp_q;
   logic [9:0] rp_q;
   logic [10:0] lvl_q;

   // full words are refused here, so a late word never overwrites a held one
   wire logic push = i_wr && (lvl_q != 11'(attc_pkg::FIFO_DEPTH));
   wire logic pop = i_pop && (lvl_q != 11'h000) && !i_drop;
   wire logic [10:0] drop_w = i_drop ? {2'b00, i_drop_n} : 11'h000;

   assign o_full = (lvl_q == 11'(attc_pkg::FIFO_DEPTH));
   assign o_valid = (lvl_q != 11'h000);
   assign o_rd_data = mem[rp_q];
   assign o_level = lvl_q;

   // storage array
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wp_q] <= i_wr_data;
      end
   end

   // pointers; a drop skips the oldest scan in one step
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || i_flush) begin
         wp_q <= 10'h000;
         rp_q <= 10'h000;
         lvl_q <= 11'h000;
      end else begin
         wp_q <= wp_q + 10'(push);
         rp_q <= rp_q + 10'(pop) + drop_w[9:0];
         lvl_q <= lvl_q + 11'(push) - 11'(pop) - drop_w;
      end
   end
endmodule : attc_fifo

// file: attc_skid.sv
// two-entry buffer with valid and ready on both sides, registered outputs
module attc_skid (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // filling side
   input wire logic i_valid,
   input wire logic [15:0] i_data,
   output logic o_ready,
   // draining side
   output logic o_valid,
   output logic [15:0] o_data,
   input wire logic i_ready
);
   logic v1_q;
   logic [15:0] d1_q;

   wire logic push = i_valid && !v1_q;
   wire logic pop = o_valid && i_ready;

   assign o_ready = !v1_q;

   // head drives the port, second entry catches a word during a stall
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         v1_q <= 1'b0;
         o_data <= 16'h0000;
         d1_q <= 16'h0000;
      end else if (pop) begin
         o_valid <= v1_q || push;
         o_data <= v1_q ? d1_q : i_data;
         v1_q <= v1_q && push;
         d1_q <= i_data;
      end else if (push) begin
         o_valid <= 1'b1;
         v1_q <= o_valid;
         if (o_valid) begin
            d1_q <= i_data;
         end else begin
            o_data <= i_data;
         end
      end
   end
endmodule : attc_skid

// file: attc_top_asserts.sv
// checker: port-level properties of the acquisition sequencer
module attc_top_asserts (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // inputs
   input wire attc_pkg::attc_cfg_t i_cfg,
   input wire logic i_start,
   input wire logic i_conv_done,
   input wire logic i_dat_ready,
   // outputs
   input wire logic o_conv_start,
   input wire logic [8:0] o_conv_entry,
   input wire logic o_dat_valid,
   input wire logic [15:0] o_dat_word,
   input wire logic o_eoc_irq,
   input wire logic o_half_irq,
   input wire logic o_busy,
   input wire logic o_overflow,
   input wire logic [10:0] o_fifo_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // properties, one clock domain
   // ****
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   a_start_busy: assert property (!o_busy && i_start |=> o_busy)
      else $error("busy missing after start");
   a_conv_pulse: assert property (o_conv_start |=> !o_conv_start)
      else $error("launch longer than one clock");
   a_conv_busy: assert property (o_conv_start |-> o_busy)
      else $error("launch while idle");
   a_entry_range: assert property (o_conv_start && i_cfg.spscan != 9'h000
      |-> o_conv_entry < i_cfg.spscan) else $error("entry beyond scan size");
   a_eoc_cause: assert property (o_eoc_irq |-> i_cfg.xfer == attc_pkg::ATTC_X_EOC
      && ($past(i_conv_done) || $past(i_conv_done, 2))) else $error("eoc without word");
   a_half_cause: assert property (o_half_irq |-> i_cfg.xfer == attc_pkg::ATTC_X_HALF
      && o_fifo_level >= 11'h1fe) else $error("half event below level");
   a_level_cap: assert property (o_fifo_level <= 11'h400)
      else $error("fifo level above depth");
   a_ovf_sticky: assert property (o_overflow && !i_start |=> o_overflow)
      else $error("overflow dropped");
   a_word_hold: assert property (o_dat_valid && !i_dat_ready
      |=> o_dat_valid && $stable(o_dat_word)) else $error("stalled word changed");
   c_half: cover property (o_half_irq);
   c_ovf: cover property ($rose(o_overflow));
   c_entry: cover property (o_conv_start && o_conv_entry == 9'h003);
endmodule : attc_top_asserts

bind attc_top attc_top_asserts u_chk (.i_sys_clk, .i_rst, .i_cfg, .i_start,
   .i_conv_done, .i_dat_ready, .o_conv_start, .o_conv_entry, .o_dat_valid,
   .o_dat_word, .o_eoc_irq, .o_half_irq, .o_busy, .o_overflow, .o_fifo_level);

// file: attc_far_model.sv
// far-side model: converter answering launches, stalling host sink
module attc_far_model (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // converter
   input wire logic i_conv_start,
   input wire logic [8:0] i_conv_entry,
   output logic o_conv_done = 1'b0,
   output logic [15:0] o_conv_data = 16'h0000,
   // sink
   input wire logic i_hold,
   output logic o_dat_ready = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pend_q = 3'h0;
   logic [8:0] ent_q = 9'h000;
   // ****
   // converter and sink
   // ****
   // data bus toggles between results so a stale word never looks valid
   always @(posedge i_sys_clk) begin
      if (i_rst) begin
         pend_q <= 3'h0;
         o_conv_done <= 1'b0;
         o_dat_ready <= 1'b0;
      end else begin
         pend_q <= {pend_q[1:0], i_conv_start};
         if (i_conv_start) ent_q <= i_conv_entry;
         o_conv_done <= pend_q[2];
         o_conv_data <= pend_q[2] ? {7'h2a, ent_q} : ~o_conv_data;
         o_dat_ready <= !i_hold && ($urandom % 4 != 0);
      end
   end
endmodule : attc_far_model

// file: testbench.sv
// bench: queue-checked runs of every trigger mode with eoc and dma transfer, plus a count-checked half transfer fill
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, start = 0, trig = 0, hold = 0, drop = 0, etb = 0;
   logic cdone, cstart, valid, ready, eoc, half, busy, ovf;
   logic [15:0] cdata, word;
   logic [8:0] entry;
   logic [10:0] level;
   attc_pkg::attc_cfg_t cfg = '0;
   int failures = 0, compares = 0, convs = 0, eocs = 0, halfs = 0, cyc = 0, bcyc = 0;
   logic [15:0] exp_q[$];
   // ****
   // harness
   // ****
   attc_top u_dut (.i_sys_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_start(start),
      .i_ext_trig(trig), .i_ext_tb(etb), .o_conv_start(cstart), .o_conv_entry(entry),
      .i_conv_done(cdone), .i_conv_data(cdata), .o_dat_valid(valid), .o_dat_word(word),
      .i_dat_ready(ready), .o_eoc_irq(eoc), .o_half_irq(half), .o_busy(busy),
      .o_overflow(ovf), .o_fifo_level(level));
   attc_far_model u_far (.i_sys_clk(clk), .i_rst(rst), .i_conv_start(cstart),
      .i_conv_entry(entry), .o_conv_done(cdone), .o_conv_data(cdata), .i_hold(hold),
      .o_dat_ready(ready));
   initial forever #5 clk = ~clk;
   // external timebase pin, one rising edge every two clocks
   always @(posedge clk) etb <= ~etb;
   task automatic stop_test;
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // hang guard, then watcher taking the oldest note per accepted word
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         stop_test();
      end else if (!rst) begin
         if (cstart) convs++;
         if (busy) bcyc++;
         if (eoc) eocs++;
         if (half) halfs++;
         if (valid && ready && !drop) begin
            if (exp_q.size() != 0) check(word, exp_q.pop_front(), "word");
            else check(16'h0000, 16'h0001, "extra word");
         end
      end
   end
   function automatic attc_pkg::attc_cfg_t mk(input attc_pkg::attc_mode_t m,
         input attc_pkg::attc_xfer_t x, input int sp, input int sc);
      attc_pkg::attc_cfg_t c;
      c = '0;
      c.mode = m;
      c.xfer = x;
      c.spscan = 9'(sp);
      c.scan_count = 24'(sc);
      c.smp_int = 16'h0002;
      c.scan_int = 24'(2 * sp + 2);
      return c;
   endfunction : mk
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step
   task automatic apply(input attc_pkg::attc_cfg_t c);
      @(posedge clk);
      cfg <= c;
      trig <= c.trig_falling;
      repeat (4) @(posedge clk);
   endtask : apply
   task automatic kick;
      convs = 0;
      bcyc = 0;
      eocs = 0;
      halfs = 0;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : kick
   task automatic idle;
      do step(); while (busy !== 1'b0 || exp_q.size() != 0);
   endtask : idle
   // one qualifying edge, then back to idle level
   task automatic pulse;
      trig <= ~cfg.trig_falling;
      repeat (8) @(posedge clk);
      trig <= cfg.trig_falling;
   endtask : pulse
   task automatic go(input int n, input int nt, input int gap, input bit early);
      int i;
      for (i = 0; i < n; i++) exp_q.push_back({7'h2a, 9'(i % cfg.spscan)});
      kick();
      if (early) begin
         repeat (20) @(posedge clk);
         pulse();
      end
      for (i = 0; i < nt; i++) begin
         repeat (gap) @(posedge clk);
         if (i == 0 && cfg.mode >= attc_pkg::ATTC_POST) check(16'(convs), 16'h0000, "waiting");
         pulse();
         if (i == 0 && cfg.mode == attc_pkg::ATTC_DELAY) begin
            repeat (240) @(posedge clk);
            check(16'(convs), 16'h0000, "delaying");
         end
      end
      idle();
      if (cfg.mode inside {attc_pkg::ATTC_SOFT, attc_pkg::ATTC_POST, attc_pkg::ATTC_DELAY})
         check(16'(convs), 16'(n), "launches");
   endtask : go
   // ****
   // scenarios
   // ****
   initial begin
      attc_pkg::attc_cfg_t c;
      int k;
      void'($urandom(10528));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      // fill with sink stalled until words are refused, then drain
      c = mk(attc_pkg::ATTC_SOFT, attc_pkg::ATTC_X_HALF, 1, 2048);
      c.smp_int = 16'h0001;
      c.scan_int = 24'h00_0001;
      hold <= 1'b1;
      apply(c);
      kick();
      idle();
      check(16'(halfs), 16'h0001, "half events");
      check(16'(level), 16'h0400, "level");
      check(16'(ovf), 16'h0001, "overflow");
      drop <= 1'b1;
      hold <= 1'b0;
      do step(); while (level !== 11'h000 || valid !== 1'b0);
      drop <= 1'b0;
      // software start, end-of-conversion events, overflow cleared, both timebases
      // 13 ticks: about 27 clocks on the pin, never under 48 on the internal one
      for (k = 0; k < 2; k++) begin
         c = mk(attc_pkg::ATTC_SOFT, attc_pkg::ATTC_X_EOC, 3, 2);
         c.tb_ext = k[0];
         apply(c);
         go(6, 0, 0, 0);
         check(16'(eocs), 16'h0006, "eoc events");
         check(16'(ovf), 16'h0000, "overflow");
         check(16'(bcyc < 40), 16'(k), "timebase pace");
      end
      for (k = 0; k < 2; k++) begin
         c = mk(attc_pkg::ATTC_POST, attc_pkg::ATTC_X_DMA, 3, 2);
         c.trig_falling = k[0];
         apply(c);
         go(6, 1, 150, 0);
      end
      for (k = 0; k < 2; k++) begin
         c = mk(attc_pkg::ATTC_DELAY, attc_pkg::ATTC_X_DMA, 2, 2);
         c.dly_smp_clk = k[0];
         c.dly_count = k[0] ? 16'h0020 : 16'h0040;
         apply(c);
         go(4, 1, 50, 0);
      end
      c = mk(attc_pkg::ATTC_POST, attc_pkg::ATTC_X_DMA, 2, 1);
      c.retrig_en = 1'b1;
      c.retrig_total = 16'h0002;
      apply(c);
      go(4, 2, 200, 0);
      // guarded pre-trigger: the early edge must be ignored
      c = mk(attc_pkg::ATTC_PRE, attc_pkg::ATTC_X_DMA, 4, 0);
      c.pre_count = 16'h0002;
      c.guard_en = 1'b1;
      apply(c);
      go(8, 1, 400, 1);
      // unguarded pre-trigger: the early edge ends the run after one whole scan
      c.guard_en = 1'b0;
      apply(c);
      go(4, 0, 0, 1);
      // two pre scans, so an early edge that got through would shorten the data
      c = mk(attc_pkg::ATTC_MID, attc_pkg::ATTC_X_DMA, 2, 2);
      c.pre_count = 16'h0002;
      c.guard_en = 1'b1;
      apply(c);
      go(8, 1, 300, 1);
      stop_test();
   end
endmodule : testbench
